// file: common/status_pkg.sv
// Constants for the sensor status flag register bank.
// Assumes an 8-bit register port with byte addresses on the device clock.
package status_pkg;
   localparam logic [7:0] OFS_MEASURE_STATE = 8'h71;
   localparam logic [7:0] OFS_EVENT_FLAGS = 8'h93;
   localparam logic [7:0] OFS_SAT_VALID = 8'hA3;
   localparam logic [7:0] OFS_CAUSE_STATE = 8'hA4;
   localparam logic [7:0] RST_MEASURE_STATE = 8'h00;
   localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
   localparam logic [7:0] RST_SAT_VALID = 8'h00;
   localparam logic [7:0] RST_CAUSE_STATE = 8'h00;
   // Measurement state fields.
   localparam int BIT_READY = 0;
   localparam int BIT_WAIT_SYNC = 1;
   // Primary event fields.
   localparam int BIT_SYSTEM_EVENT = 0;
   localparam int BIT_CAL_EVENT = 1;
   localparam int BIT_BUFFER_LEVEL_EVENT = 2;
   localparam int BIT_SPECTRAL_THRESHOLD_EVENT = 3;
   localparam int BIT_SATURATION_EVENT = 7;
   // Saturation and valid fields.
   localparam int BIT_FLICKER_COUNT_OVERFLOW = 0;
   localparam int BIT_FLICKER_FRONTEND_OVERLOAD = 1;
   localparam int BIT_SPECTRAL_FRONTEND_OVERLOAD = 3;
   localparam int BIT_SPECTRAL_COUNT_OVERFLOW = 4;
   localparam int BIT_SPECTRAL_RESULT_VALID = 6;
   // Threshold cause fields.
   localparam int BIT_BELOW_LOW_LIMIT_CAUSE = 4;
   localparam int BIT_ABOVE_HIGH_LIMIT_CAUSE = 5;
   // Writable mask of the event register.
   localparam logic [7:0] EVENT_MASK = 8'h8F;
   localparam int THRESH_W = 16;
   localparam logic [7:0] PERSIST_RST = 8'h00;
   typedef enum logic [1:0] {
      TRIG_FREE,
      TRIG_SINGLE_PULSE,
      TRIG_DUAL_PULSE,
      TRIG_OTHER
   } trigger_mode_t;
endpackage

// file: hw/pin_sync.sv
// Two flip-flop synchroniser for one level input.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/10ps
module pin_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Level
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// file: hw/threshold_check.sv
// Threshold compare with persistence for the monitored spectral channel.
// Assumes one sample strobe per completed measurement, on clk_i.
`timescale 1ns/10ps
module threshold_check #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Sample and limits
   input wire logic sample_valid_i,
   input wire logic [WIDTH-1:0] sample_i,
   input wire logic [WIDTH-1:0] low_limit_i,
   input wire logic [WIDTH-1:0] high_limit_i,
   input wire logic [7:0] persistence_count_i,
   // Events, one cycle each
   output logic low_event_o,
   output logic high_event_o
);
   logic [7:0] run_q;
   logic out_of_range;
   logic below;
   logic above;
   logic hit;

   assign below = sample_i < low_limit_i;
   assign above = sample_i > high_limit_i;
   assign out_of_range = below | above;
   // A persistence of zero fires on every out-of-range sample.
   assign hit = sample_valid_i && out_of_range && (run_q >= persistence_count_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 8'h00;
         low_event_o <= 1'b0;
         high_event_o <= 1'b0;
      end else begin
         if (sample_valid_i) begin
            if (!out_of_range) begin
               run_q <= 8'h00;
            end else if (run_q != 8'hFF) begin
               run_q <= run_q + 8'h01;
            end
         end
         low_event_o <= hit && below;
         high_event_o <= hit && above;
      end
   end
endmodule

// file: hw/sensor_status_flags.sv
// Status and event flag register bank of a multi-channel spectral sensor.
// Assumes the serial register front end presents byte reads and writes on clk_i,
// and that measurement logic delivers one-cycle event strobes on the same clock.
//
// Overview of operation
// - Wait-for-sync reads 1 while a sync trigger mode holds off integration.
// - Ready reads 0 while measuring and 1 once the measurement is ready.
// - Writing 1 to a primary event bit clears that bit; bit 3 also clears the cause register, bit 7 the saturation causes if none is active.
// - Writing 0 to a set primary event bit leaves it set.
// - Saturation sets event bit 7 when its interrupt enable is set.
// - Threshold match with persistence sets event bit 3 when enabled.
// - Buffer fill condition sets event bit 2 when its enable is set.
// - Buffer flag rises again after clear while the fill condition holds.
// - System event sets event bit 0 when its enable is set.
// - Spectral result valid bit 6 sets when a measurement completes.
// - Spectral count overflow sets bit 4 of the second status register.
// - Spectral front end overload sets bit 3 of the second status register.
// - Flicker front end overload sets bit 1 of the second status register.
// - Flicker count overflow sets bit 0 of the second status register.
// - High limit cause sets bit 5 of the third status register.
// - Low limit cause sets bit 4 of the third status register.
// - Low event when sample is under the low limit and persistence met.
// - High event when sample is over the high limit and persistence met.
// - Mux command done is one source of the system event.
`timescale 1ns/10ps
module sensor_status_flags
   import status_pkg::*;
#(
   parameter int THRESH_WIDTH = status_pkg::THRESH_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Configuration from other registers
   input wire status_pkg::trigger_mode_t trigger_mode_i,
   input wire logic saturation_irq_enable_i,
   input wire logic spectral_irq_enable_i,
   input wire logic buffer_irq_enable_i,
   input wire logic system_irq_enable_i,
   input wire logic [7:0] persistence_count_i,
   input wire logic [THRESH_WIDTH-1:0] low_limit_i,
   input wire logic [THRESH_WIDTH-1:0] high_limit_i,
   // Measurement engine state
   input wire logic measuring_i,
   input wire logic integration_armed_i,
   input wire logic measure_done_i,
   input wire logic [THRESH_WIDTH-1:0] monitor_sample_i,
   // Saturation, system, calibration and buffer sources
   input wire logic spectral_count_overflow_i,
   input wire logic spectral_frontend_overload_i,
   input wire logic flicker_frontend_overload_i,
   input wire logic flicker_count_overflow_i,
   input wire logic mux_command_done_i,
   input wire logic other_system_event_i,
   input wire logic cal_event_i,
   input wire logic buffer_level_met_i,
   input wire logic buffer_write_i,
   // Sync pin, asynchronous
   input wire logic sync_pin_i,
   // Flag outputs
   output logic [7:0] event_flags_o,
   output logic wait_sync_o
);
   import status_pkg::*;

   logic [7:0] event_q;
   logic [7:0] event_d;
   logic [7:0] sat_q;
   logic [7:0] sat_d;
   logic [7:0] cause_q;
   logic [7:0] cause_d;
   logic ready_q;
   logic wait_sync_q;
   logic [7:0] stat_spare_q;
   logic sync_pin_s;
   logic sync_pin_prev_q;
   logic sync_rise;
   logic low_event;
   logic high_event;
   logic sync_mode;
   logic wr_event;
   logic wr_state;
   logic [7:0] clear_mask;
   logic [7:0] set_mask;
   logic saturation_any;
   logic [7:0] read_mux;

   pin_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(sync_pin_i),
      .sync_o(sync_pin_s)
   );

   threshold_check #(
      .WIDTH(THRESH_WIDTH)
   ) u_thresh (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sample_valid_i(measure_done_i),
      .sample_i(monitor_sample_i),
      .low_limit_i(low_limit_i),
      .high_limit_i(high_limit_i),
      .persistence_count_i(persistence_count_i),
      .low_event_o(low_event),
      .high_event_o(high_event)
   );

   // Address decode.
   assign wr_event = reg_wr_i && (reg_addr_i == OFS_EVENT_FLAGS);
   assign wr_state = reg_wr_i && (reg_addr_i == OFS_MEASURE_STATE);

   assign sync_mode = (trigger_mode_i == TRIG_SINGLE_PULSE) ||
                      (trigger_mode_i == TRIG_DUAL_PULSE);
   assign sync_rise = sync_pin_s && !sync_pin_prev_q;

   assign saturation_any = spectral_count_overflow_i | spectral_frontend_overload_i |
                           flicker_frontend_overload_i | flicker_count_overflow_i;

   // Only ones clear; zeros leave the flags untouched.
   assign clear_mask = wr_event ? (reg_wdata_i & EVENT_MASK) : 8'h00;

   always_comb begin
      set_mask = 8'h00;
      set_mask[BIT_SATURATION_EVENT] = saturation_irq_enable_i && saturation_any;
      set_mask[BIT_SPECTRAL_THRESHOLD_EVENT] = spectral_irq_enable_i &&
                                               (low_event || high_event);
      // A level condition that holds re-raises the flag after a clear.
      set_mask[BIT_BUFFER_LEVEL_EVENT] = buffer_irq_enable_i && buffer_level_met_i &&
                                         (buffer_write_i || !event_q[BIT_BUFFER_LEVEL_EVENT]
                                          && !clear_mask[BIT_BUFFER_LEVEL_EVENT]);
      set_mask[BIT_CAL_EVENT] = cal_event_i;
      set_mask[BIT_SYSTEM_EVENT] = system_irq_enable_i &&
                                   (mux_command_done_i || other_system_event_i);
   end

   // Set wins over a clear in the same cycle.
   assign event_d = ((event_q & ~clear_mask) | set_mask) & EVENT_MASK;

   always_comb begin
      sat_d = sat_q;
      if (measure_done_i) begin
         sat_d[BIT_SPECTRAL_RESULT_VALID] = 1'b1;
      end
      if (measuring_i && !measure_done_i) begin
         sat_d[BIT_SPECTRAL_RESULT_VALID] = 1'b0;
      end
      if (spectral_count_overflow_i) begin
         sat_d[BIT_SPECTRAL_COUNT_OVERFLOW] = 1'b1;
      end
      if (spectral_frontend_overload_i) begin
         sat_d[BIT_SPECTRAL_FRONTEND_OVERLOAD] = 1'b1;
      end
      if (flicker_frontend_overload_i) begin
         sat_d[BIT_FLICKER_FRONTEND_OVERLOAD] = 1'b1;
      end
      if (flicker_count_overflow_i) begin
         sat_d[BIT_FLICKER_COUNT_OVERFLOW] = 1'b1;
      end
      // Saturation causes clear with the event flag that summarises them.
      if (clear_mask[BIT_SATURATION_EVENT] && !saturation_any) begin
         sat_d[BIT_SPECTRAL_COUNT_OVERFLOW] = 1'b0;
         sat_d[BIT_SPECTRAL_FRONTEND_OVERLOAD] = 1'b0;
         sat_d[BIT_FLICKER_FRONTEND_OVERLOAD] = 1'b0;
         sat_d[BIT_FLICKER_COUNT_OVERFLOW] = 1'b0;
      end
   end

   always_comb begin
      cause_d = cause_q;
      if (clear_mask[BIT_SPECTRAL_THRESHOLD_EVENT]) begin
         cause_d = 8'h00;
      end
      if (high_event) begin
         cause_d[BIT_ABOVE_HIGH_LIMIT_CAUSE] = 1'b1;
      end
      if (low_event) begin
         cause_d[BIT_BELOW_LOW_LIMIT_CAUSE] = 1'b1;
      end
   end

   always_comb begin
      read_mux = 8'h00;
      unique case (reg_addr_i)
         OFS_MEASURE_STATE: begin
            read_mux = {stat_spare_q[7:2], wait_sync_q, ready_q};
         end
         OFS_EVENT_FLAGS: begin
            read_mux = event_q;
         end
         OFS_SAT_VALID: begin
            read_mux = sat_q;
         end
         OFS_CAUSE_STATE: begin
            read_mux = cause_q;
         end
         default: begin
            read_mux = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_q <= RST_EVENT_FLAGS;
         sat_q <= RST_SAT_VALID;
         cause_q <= RST_CAUSE_STATE;
         stat_spare_q <= RST_MEASURE_STATE;
         ready_q <= 1'b0;
         wait_sync_q <= 1'b0;
         sync_pin_prev_q <= 1'b0;
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
         event_flags_o <= RST_EVENT_FLAGS;
         wait_sync_o <= 1'b0;
      end else begin
         event_q <= event_d;
         sat_q <= sat_d;
         cause_q <= cause_d;
         sync_pin_prev_q <= sync_pin_s;
         if (wr_state) begin
            stat_spare_q <= {reg_wdata_i[7:2], 2'b00};
         end
         // Ready drops on a new measurement and rises at its completion.
         if (measure_done_i) begin
            ready_q <= 1'b1;
         end else if (measuring_i) begin
            ready_q <= 1'b0;
         end
         // Held off until the pin pulse arrives in a sync mode.
         if (!sync_mode || sync_rise) begin
            wait_sync_q <= 1'b0;
         end else if (integration_armed_i && !measuring_i) begin
            wait_sync_q <= 1'b1;
         end
         reg_rdata_o <= reg_rd_i ? read_mux : 8'h00;
         reg_rvalid_o <= reg_rd_i;
         event_flags_o <= event_d;
         wait_sync_o <= wait_sync_q;
      end
   end

   // Assertions.
   property p_clear_one;
      @(posedge clk_i) disable iff (rst_i)
      (wr_event && reg_wdata_i[BIT_CAL_EVENT] && !cal_event_i) |=> !event_q[BIT_CAL_EVENT];
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("event bit not cleared");

   property p_zero_keeps;
      @(posedge clk_i) disable iff (rst_i)
      (wr_event && !reg_wdata_i[BIT_SYSTEM_EVENT] && event_q[BIT_SYSTEM_EVENT])
      |=> event_q[BIT_SYSTEM_EVENT];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

   property p_sat_set;
      @(posedge clk_i) disable iff (rst_i)
      (saturation_irq_enable_i && spectral_frontend_overload_i)
      |=> event_q[BIT_SATURATION_EVENT] && sat_q[BIT_SPECTRAL_FRONTEND_OVERLOAD];
   endproperty
   a_sat_set: assert property (p_sat_set) else $error("saturation not flagged");

   property p_thresh_set;
      @(posedge clk_i) disable iff (rst_i)
      (spectral_irq_enable_i && high_event) |=> event_q[BIT_SPECTRAL_THRESHOLD_EVENT]
      && cause_q[BIT_ABOVE_HIGH_LIMIT_CAUSE];
   endproperty
   a_thresh_set: assert property (p_thresh_set) else $error("threshold not flagged");

   property p_system_set;
      @(posedge clk_i) disable iff (rst_i)
      (system_irq_enable_i && mux_command_done_i) |=> event_q[BIT_SYSTEM_EVENT];
   endproperty
   a_system_set: assert property (p_system_set) else $error("system event lost");

   property p_valid_set;
      @(posedge clk_i) disable iff (rst_i)
      measure_done_i |=> sat_q[BIT_SPECTRAL_RESULT_VALID] && ready_q;
   endproperty
   a_valid_set: assert property (p_valid_set) else $error("valid not set");

   property p_no_spurious;
      @(posedge clk_i) disable iff (rst_i)
      (!saturation_irq_enable_i && !event_q[BIT_SATURATION_EVENT])
      |=> !event_q[BIT_SATURATION_EVENT];
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("masked event set");

   sequence s_cleared_buffer;
      wr_event && reg_wdata_i[BIT_BUFFER_LEVEL_EVENT];
   endsequence
   property p_buffer_rearm;
      @(posedge clk_i) disable iff (rst_i)
      s_cleared_buffer ##1 (buffer_irq_enable_i && buffer_level_met_i && buffer_write_i)
      |=> event_q[BIT_BUFFER_LEVEL_EVENT];
   endproperty
   a_buffer_rearm: assert property (p_buffer_rearm) else $error("buffer flag not rearmed");

   property p_buffer_set;
      @(posedge clk_i) disable iff (rst_i)
      (buffer_irq_enable_i && buffer_level_met_i && buffer_write_i)
      |=> event_q[BIT_BUFFER_LEVEL_EVENT];
   endproperty
   a_buffer_set: assert property (p_buffer_set) else $error("buffer flag not set");

   property p_cal_set;
      @(posedge clk_i) disable iff (rst_i)
      cal_event_i |=> event_q[BIT_CAL_EVENT];
   endproperty
   a_cal_set: assert property (p_cal_set) else $error("calibration flag not set");

   property p_wait_sync_set;
      @(posedge clk_i) disable iff (rst_i)
      (sync_mode && !sync_rise && integration_armed_i && !measuring_i) |=> wait_sync_q;
   endproperty
   a_wait_sync_set: assert property (p_wait_sync_set) else $error("wait flag not set");

   property p_wait_sync_clear;
      @(posedge clk_i) disable iff (rst_i)
      (!sync_mode || sync_rise) |=> !wait_sync_q;
   endproperty
   a_wait_sync_clear: assert property (p_wait_sync_clear) else $error("wait flag stuck");

   property p_ready_busy;
      @(posedge clk_i) disable iff (rst_i)
      (measuring_i && !measure_done_i) |=> !ready_q;
   endproperty
   a_ready_busy: assert property (p_ready_busy) else $error("ready during measurement");

   property p_low_cause;
      @(posedge clk_i) disable iff (rst_i)
      low_event |=> cause_q[BIT_BELOW_LOW_LIMIT_CAUSE];
   endproperty
   a_low_cause: assert property (p_low_cause) else $error("low cause not set");

   // The high path takes one cycle in the comparator and one in the event register.
   sequence s_high_sample;
      measure_done_i && (monitor_sample_i > high_limit_i) && (persistence_count_i == 8'h00);
   endsequence
   property p_high_path;
      @(posedge clk_i) disable iff (rst_i)
      (s_high_sample ##1 spectral_irq_enable_i)
      |=> event_q[BIT_SPECTRAL_THRESHOLD_EVENT] && cause_q[BIT_ABOVE_HIGH_LIMIT_CAUSE];
   endproperty
   a_high_path: assert property (p_high_path) else $error("high sample not flagged");
endmodule

// file: dv/status_host.sv
// Host model for the status register bank: single-byte register reads and writes.
// Assumes the bank samples its strobes on the rising edge of clk_i.
`timescale 1ns/10ps
module status_host (
   // Clock
   input wire logic clk_i,
   // Register port
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end

   // Idle address and data show the inverse of the last value, so a stale byte never matches.
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= addr;
      reg_wdata_o <= data;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~addr;
      reg_wdata_o <= ~data;
   endtask

   task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(posedge clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= addr;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~addr;
      @(posedge clk_i);
      data = reg_rdata_i;
      ok = reg_rvalid_i;
   endtask
endmodule

// file: dv/sensor_status_flags_test.sv
// Self-checking bench for the status flag register bank.
// Assumes the host model issues register cycles and the bench drives the event sources.
`timescale 1ns/10ps
module sensor_status_flags_test;
   import status_pkg::*;
   logic clk_i, rst_i, reg_wr, reg_rd, reg_rvalid, measuring, armed, sync_pin, level_met;
   logic wait_sync;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, persist, event_flags;
   logic [3:0] en;
   logic [8:0] src;
   logic [15:0] low, high, sample;
   trigger_mode_t trig;
   int errors, cmp_count;

   status_host status_host_i (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
      .reg_rvalid_i(reg_rvalid));

   sensor_status_flags #(.THRESH_WIDTH(THRESH_W)) sensor_status_flags_i (
      .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
      .reg_rvalid_o(reg_rvalid), .trigger_mode_i(trig), .saturation_irq_enable_i(en[0]),
      .spectral_irq_enable_i(en[1]), .buffer_irq_enable_i(en[2]),
      .system_irq_enable_i(en[3]), .persistence_count_i(persist), .low_limit_i(low),
      .high_limit_i(high), .measuring_i(measuring), .integration_armed_i(armed),
      .measure_done_i(src[8]), .monitor_sample_i(sample),
      .spectral_count_overflow_i(src[0]), .spectral_frontend_overload_i(src[1]),
      .flicker_frontend_overload_i(src[2]), .flicker_count_overflow_i(src[3]),
      .mux_command_done_i(src[4]), .other_system_event_i(src[5]), .cal_event_i(src[6]),
      .buffer_level_met_i(level_met), .buffer_write_i(src[7]), .sync_pin_i(sync_pin),
      .event_flags_o(event_flags), .wait_sync_o(wait_sync));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask

   // Only the bits under the mask are compared; the rest belong to other scenarios.
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
      logic [7:0] d;
      logic ok;
      status_host_i.rd(a, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(d & m, exp);
   endtask

   task automatic pulse(input logic [8:0] m);
      @(posedge clk_i);
      src <= m;
      @(posedge clk_i);
      src <= 9'h000;
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      test_done();
   end

   initial begin
      rst_i = 1'b1;
      {measuring, armed, sync_pin, level_met} = 4'h0;
      en = 4'h0;
      src = 9'h000;
      persist = 8'h00;
      low = 16'h0100;
      high = 16'h8000;
      sample = 16'h8000;
      trig = TRIG_FREE;
      errors = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(OFS_MEASURE_STATE, RST_MEASURE_STATE);
      rchk(OFS_EVENT_FLAGS, RST_EVENT_FLAGS);
      rchk(OFS_SAT_VALID, RST_SAT_VALID);
      rchk(OFS_CAUSE_STATE, RST_CAUSE_STATE);
      rchk(8'h50, 8'h00);
      // With every enable off only the calibration flag may rise.
      pulse(9'h07F);
      rchk(OFS_EVENT_FLAGS, 8'h02);
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h02);
      rchk(OFS_EVENT_FLAGS, 8'h00);
      @(posedge clk_i);
      en <= 4'hF;
      pulse(9'h05F);
      rchk(OFS_EVENT_FLAGS, 8'h83);
      chk(event_flags, 8'h83);
      rchk(OFS_SAT_VALID, 8'h1B);
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h00);
      rchk(OFS_EVENT_FLAGS, 8'h83);
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h01);
      rchk(OFS_EVENT_FLAGS, 8'h82);
      status_host_i.wr(OFS_SAT_VALID, 8'hFF);
      status_host_i.wr(OFS_CAUSE_STATE, 8'hFF);
      rchk(OFS_SAT_VALID, 8'h1B);
      rchk(OFS_CAUSE_STATE, 8'h00);
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h82);
      rchk(OFS_EVENT_FLAGS, 8'h00);
      pulse(9'h020);
      rchk(OFS_EVENT_FLAGS, 8'h01);
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h01);
      @(posedge clk_i);
      level_met <= 1'b1;
      rchk(OFS_EVENT_FLAGS, 8'h04);
      // New data lands in the cycle before the write, in the write cycle and in the cycle after it.
      src <= 9'h080;
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h04);
      @(posedge clk_i);
      src <= 9'h000;
      rchk(OFS_EVENT_FLAGS, 8'h04);
      @(posedge clk_i);
      level_met <= 1'b0;
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h04);
      rchk(OFS_EVENT_FLAGS, 8'h00);
      // A sample equal to the high limit is not above it.
      pulse(9'h100);
      rchk(OFS_EVENT_FLAGS, 8'h00);
      @(posedge clk_i);
      sample <= 16'h8001;
      pulse(9'h100);
      rchk(OFS_EVENT_FLAGS, 8'h08);
      rchk(OFS_CAUSE_STATE, 8'h20);
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h08);
      @(posedge clk_i);
      sample <= 16'h00FF;
      pulse(9'h100);
      rchk(OFS_CAUSE_STATE, 8'h10);
      status_host_i.wr(OFS_EVENT_FLAGS, 8'h08);
      @(posedge clk_i);
      // An in-range sample restarts the run left over from the earlier samples.
      persist <= 8'h02;
      sample <= 16'h1000;
      pulse(9'h100);
      sample <= 16'h0000;
      pulse(9'h100);
      pulse(9'h100);
      rchk(OFS_EVENT_FLAGS, 8'h00);
      pulse(9'h100);
      rchk(OFS_EVENT_FLAGS, 8'h08);
      rchk(OFS_SAT_VALID, 8'h40, 8'h40);
      rchk(OFS_MEASURE_STATE, 8'h01, 8'h01);
      @(posedge clk_i);
      measuring <= 1'b1;
      status_host_i.wr(OFS_MEASURE_STATE, 8'hFF);
      rchk(OFS_MEASURE_STATE, 8'hFC);
      @(posedge clk_i);
      measuring <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_i);
         trig <= (i == 0) ? TRIG_SINGLE_PULSE : TRIG_DUAL_PULSE;
         armed <= 1'b1;
         sync_pin <= 1'b0;
         repeat (4) @(posedge clk_i);
         rchk(OFS_MEASURE_STATE, 8'h02, 8'h02);
         chk({7'h00, wait_sync}, 8'h01);
         // The engine starts integrating once the pulse arrives.
         sync_pin <= 1'b1;
         measuring <= 1'b1;
         repeat (5) @(posedge clk_i);
         rchk(OFS_MEASURE_STATE, 8'h00, 8'h02);
         chk({7'h00, wait_sync}, 8'h00);
         armed <= 1'b0;
         measuring <= 1'b0;
      end
      @(posedge clk_i);
      trig <= TRIG_FREE;
      armed <= 1'b1;
      sync_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
      rchk(OFS_MEASURE_STATE, 8'h00, 8'h02);
      test_done();
   end
endmodule
